/* File: verilog/uart_holding_irq.sv */
// Purpose: holding registers, FIFOs, start filter, line state and interrupt masking
// Assumes: host strobes and pins asynchronous, held stable over several clocks
// Notes: sample tick from a fixed divider; oversample rate set by host
`timescale 1ns/1ns
module uart_holding_irq
  import uart_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [2:0] host_addr,
  input wire logic [7:0] host_data_bus_in,
  input wire logic host_cs_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic rx_line,
  input wire logic cts_pin,
  input wire logic rts_pin,
  input wire logic dsr_pin,
  input wire logic ri_pin,
  input wire logic cd_pin,
  output logic [7:0] host_data_bus_out,
  output logic host_data_bus_oe,
  output logic tx_line,
  output logic irq_out,
  output logic sleep_out
);
  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [PIN_W-1:0] s1_reg, s2_reg, s3_reg, pin_reg;
  wire [PIN_W-1:0] pin_next = settle(s2_reg, s3_reg, pin_reg);
  wire [2:0] p_addr = pin_next[19:17];
  wire [7:0] p_data = pin_next[16:9];
  wire p_cs_n = pin_next[8];
  wire p_rd_n = pin_next[7];
  wire p_wr_n = pin_next[6];
  wire p_rx = pin_next[5];
  wire [3:0] p_modem = {pin_next[0], pin_next[1], pin_next[2], pin_next[4]};
  wire [3:0] q_modem = {pin_reg[0], pin_reg[1], pin_reg[2], pin_reg[4]};
  wire cts_rise = ~pin_reg[4] & pin_next[4];
  wire rts_rise = ~pin_reg[3] & pin_next[3];

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      s1_reg <= PIN_RST;
      s2_reg <= PIN_RST;
      s3_reg <= PIN_RST;
      pin_reg <= PIN_RST;
    end
    else
    begin
      s1_reg <= {host_addr, host_data_bus_in, host_cs_n, host_rd_n, host_wr_n,
        rx_line, cts_pin, rts_pin, dsr_pin, ri_pin, cd_pin};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_reg <= pin_next;
    end
  end

  // read acts at strobe start, write at strobe end
  wire rd_go = pin_reg[7] & ~p_rd_n & ~p_cs_n;
  wire rd_end = ~pin_reg[7] & p_rd_n;
  wire wr_go = ~pin_reg[6] & p_wr_n & ~p_cs_n;
  wire rd_hold = rd_go & (p_addr == OFS_HOLD);
  wire rd_src = rd_go & (p_addr == OFS_SRC_CTRL);
  wire rd_line = rd_go & (p_addr == OFS_LINE);
  wire rd_modem = rd_go & (p_addr == OFS_MODEM);
  wire wr_hold = wr_go & (p_addr == OFS_HOLD);
  wire wr_mask = wr_go & (p_addr == OFS_MASK);
  wire wr_ctrl = wr_go & (p_addr == OFS_SRC_CTRL);
  wire wr_sample = wr_go & (p_addr == OFS_SAMPLE);
  wire wr_enh = wr_go & (p_addr == OFS_ENH);

  ////////////////////////////////////////////////////////////////////////////////
  // control registers
  logic [7:0] irq_mask_reg, enhanced_feature_reg;
  logic [1:0] oversample_sel, trig_sel_reg;
  logic fifo_en_reg;
  wire rx_clr = wr_ctrl & p_data[CTRL_RX_CLR];
  wire tx_clr = wr_ctrl & p_data[CTRL_TX_CLR];

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      irq_mask_reg <= MASK_RST;
      enhanced_feature_reg <= ENH_RST;
      oversample_sel <= SAMPLE_RST;
      trig_sel_reg <= TRIG_RST;
      fifo_en_reg <= 1'b0;
    end
    else
    begin
      if (wr_mask)
      begin
        irq_mask_reg[3:0] <= p_data[3:0];
        if (enhanced_feature_reg[ENH_ENABLE])
        begin
          irq_mask_reg[7:4] <= p_data[7:4];
        end
      end
      if (wr_enh)
      begin
        enhanced_feature_reg <= p_data;
      end
      if (wr_sample)
      begin
        oversample_sel <= p_data[1:0];
      end
      if (wr_ctrl)
      begin
        fifo_en_reg <= p_data[CTRL_FIFO_EN];
        trig_sel_reg <= p_data[7:6];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sample tick and receiver
  logic [7:0] tick_cnt_reg;
  wire tick = (tick_cnt_reg == TICK_DIV - 8'h01);
  wire [4:0] osr = osr_of(oversample_sel);
  wire [4:0] half = {1'b0, osr[4:1]};
  rx_state_t rx_state_reg;
  logic [4:0] rx_cnt_reg;
  logic [2:0] rx_bits_reg;
  logic [7:0] rx_shift_reg;
  wire rx_fall = pin_reg[5] & ~p_rx;
  wire rx_mid = tick & (rx_cnt_reg == half - 5'h01);
  wire rx_bit_end = tick & (rx_cnt_reg == osr - 5'h01);
  wire rx_done = (rx_state_reg == RX_STOP) & rx_bit_end;
  wire [2:0] rx_err_in = {~p_rx & (rx_shift_reg == 8'h00), ~p_rx, 1'b0};

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      tick_cnt_reg <= 8'h00;
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= 5'h00;
      rx_bits_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
    end
    else
    begin
      tick_cnt_reg <= tick ? 8'h00 : tick_cnt_reg + 8'h01;
      if (tick)
      begin
        rx_cnt_reg <= rx_cnt_reg + 5'h01;
      end
      case (rx_state_reg)
        RX_IDLE:
        begin
          rx_cnt_reg <= 5'h00;
          if (rx_fall)
          begin
            rx_state_reg <= RX_START;
          end
        end
        RX_START:
        begin
          if (rx_mid)
          begin
            rx_cnt_reg <= 5'h00;
            rx_bits_reg <= 3'h0;
            rx_state_reg <= p_rx ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA:
        begin
          if (rx_bit_end)
          begin
            rx_cnt_reg <= 5'h00;
            rx_shift_reg <= {p_rx, rx_shift_reg[7:1]};
            rx_bits_reg <= rx_bits_reg + 3'h1;
            if (rx_bits_reg == 3'h7)
            begin
              rx_state_reg <= RX_STOP;
            end
          end
        end
        RX_STOP:
        begin
          if (rx_bit_end)
          begin
            rx_state_reg <= RX_IDLE;
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive FIFO, data plus {break, framing, parity}
  logic [PTR_W-1:0] rx_wp_reg, rx_rp_reg;
  logic [7:0] rx_count_reg, err_cnt_reg;
  logic [10:0] rx_top;
  logic overrun_reg;
  wire rx_full = rx_count_reg == (fifo_en_reg ? 8'h80 : 8'h01);
  wire rx_push = rx_done & ~rx_full;
  wire rx_pop = rd_hold & (rx_count_reg != 8'h00);
  wire rx_any = rx_count_reg != 8'h00;
  wire top_err = rx_any & (|rx_top[10:8]);

  fifo_store #(.WIDTH(11)) rx_store (
    .ref_clk(ref_clk),
    .wr_en(rx_push),
    .wr_addr(rx_wp_reg),
    .wr_data({rx_err_in, rx_shift_reg}),
    .rd_addr(rx_rp_reg),
    .rd_data(rx_top)
  );

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n || rx_clr)
    begin
      rx_wp_reg <= 7'h00;
      rx_rp_reg <= 7'h00;
      rx_count_reg <= 8'h00;
      err_cnt_reg <= 8'h00;
    end
    else
    begin
      if (rx_push)
      begin
        rx_wp_reg <= ptr_inc(rx_wp_reg);
      end
      if (rx_pop)
      begin
        rx_rp_reg <= ptr_inc(rx_rp_reg);
      end
      rx_count_reg <= rx_count_reg + {7'h00, rx_push} - {7'h00, rx_pop};
      err_cnt_reg <= err_cnt_reg + {7'h00, rx_push & (|rx_err_in)}
        - {7'h00, rx_pop & top_err};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transmit FIFO and shifter
  logic [PTR_W-1:0] tx_wp_reg, tx_rp_reg;
  logic [7:0] tx_count_reg, tx_head;
  tx_state_t tx_state_reg;
  logic [8:0] tx_shift_reg;
  logic [3:0] tx_bits_reg;
  logic [4:0] tx_cnt_reg;
  wire tx_full = tx_count_reg == (fifo_en_reg ? 8'h80 : 8'h01);
  wire tx_push = wr_hold & ~tx_full;
  wire tx_pop = tx_state_reg == TX_LOAD;
  wire tx_drain = tx_pop & (tx_count_reg == 8'h01);
  wire tx_bit_end = tick & (tx_cnt_reg == osr - 5'h01);

  fifo_store #(.WIDTH(8)) tx_store (
    .ref_clk(ref_clk),
    .wr_en(tx_push),
    .wr_addr(tx_wp_reg),
    .wr_data(p_data),
    .rd_addr(tx_rp_reg),
    .rd_data(tx_head)
  );

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n || tx_clr)
    begin
      tx_wp_reg <= 7'h00;
      tx_rp_reg <= 7'h00;
      tx_count_reg <= 8'h00;
    end
    else
    begin
      if (tx_push)
      begin
        tx_wp_reg <= ptr_inc(tx_wp_reg);
      end
      if (tx_pop)
      begin
        tx_rp_reg <= ptr_inc(tx_rp_reg);
      end
      tx_count_reg <= tx_count_reg + {7'h00, tx_push} - {7'h00, tx_pop};
    end
  end

  // idle waits a clock so head data has settled after a push
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 9'h1ff;
      tx_bits_reg <= 4'h0;
      tx_cnt_reg <= 5'h00;
      tx_line <= 1'b1;
    end
    else
    begin
      case (tx_state_reg)
        TX_IDLE:
        begin
          if (tx_count_reg != 8'h00 && !tx_clr)
          begin
            tx_state_reg <= TX_LOAD;
          end
        end
        TX_LOAD:
        begin
          tx_shift_reg <= {1'b1, tx_head};
          tx_bits_reg <= 4'h0;
          tx_cnt_reg <= 5'h00;
          tx_line <= 1'b0;
          tx_state_reg <= TX_SEND;
        end
        TX_SEND:
        begin
          if (tick)
          begin
            tx_cnt_reg <= tx_bit_end ? 5'h00 : tx_cnt_reg + 5'h01;
          end
          if (tx_bit_end)
          begin
            tx_bits_reg <= tx_bits_reg + 4'h1;
            tx_line <= tx_shift_reg[0] | (tx_bits_reg == 4'h9);
            tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
            if (tx_bits_reg == 4'h9)
            begin
              tx_state_reg <= TX_IDLE;
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // line state, modem state, interrupt sources
  wire tx_busy = tx_state_reg != TX_IDLE;
  wire [7:0] line_state_reg = {err_cnt_reg != 8'h00,
    (tx_count_reg == 8'h00) & ~tx_busy,
    tx_count_reg == 8'h00,
    top_err & rx_top[10], top_err & rx_top[9], top_err & rx_top[8], overrun_reg,
    rx_any};
  logic [3:0] modem_delta_reg;
  wire [7:0] modem_state_reg = {q_modem, modem_delta_reg};
  wire [3:0] modem_chg = (p_modem ^ q_modem) & {1'b1, ~p_modem[2], 2'b11};
  logic tx_space_pend_reg, xoff_pend_reg, cts_pend_reg, rts_pend_reg;
  wire rx_avail_irq = fifo_en_reg ? (rx_count_reg >= rx_trigger(trig_sel_reg)) : rx_any;
  wire tx_space_irq = fifo_en_reg ? tx_space_pend_reg : (tx_count_reg == 8'h00);
  wire [7:0] pend = {cts_pend_reg, rts_pend_reg, xoff_pend_reg, 1'b0,
    |modem_delta_reg,
    |line_state_reg[4:1],
    tx_space_irq, rx_avail_irq};
  wire polled = fifo_en_reg & (irq_mask_reg[3:0] == 4'h0);
  wire [7:0] live = pend & irq_mask_reg & {8{~polled}};
  wire [5:0] src_code = live[2] ? SRC_LINE : live[0] ? SRC_RX : live[1] ? SRC_TX :
    live[3] ? SRC_MODEM : live[5] ? SRC_XOFF : (|live[7:6]) ? SRC_FLOW : SRC_NONE;
  wire [7:0] irq_source_reg = {{2{fifo_en_reg}}, src_code};
  wire xoff_seen = rx_push & (rx_shift_reg == XOFF_CHAR);

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      overrun_reg <= 1'b0;
      modem_delta_reg <= 4'h0;
      tx_space_pend_reg <= 1'b0;
      xoff_pend_reg <= 1'b0;
      cts_pend_reg <= 1'b0;
      rts_pend_reg <= 1'b0;
    end
    else
    begin
      overrun_reg <= (rx_done & rx_full) | (overrun_reg & ~rd_line);
      modem_delta_reg <= modem_chg | (modem_delta_reg & {4{~rd_modem}});
      tx_space_pend_reg <= tx_drain | (tx_space_pend_reg & ~rd_src & ~wr_hold);
      xoff_pend_reg <= xoff_seen | (xoff_pend_reg & ~rd_src);
      cts_pend_reg <= cts_rise | (cts_pend_reg & ~rd_src);
      rts_pend_reg <= rts_rise | (rts_pend_reg & ~rd_src);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // host read data and output flops
  wire [7:0] rd_mux = (p_addr == OFS_HOLD) ? rx_top[7:0] :
    (p_addr == OFS_MASK) ? irq_mask_reg :
    (p_addr == OFS_SRC_CTRL) ? irq_source_reg :
    (p_addr == OFS_SAMPLE) ? {6'h00, oversample_sel} :
    (p_addr == OFS_LINE) ? line_state_reg :
    (p_addr == OFS_MODEM) ? modem_state_reg :
    (p_addr == OFS_ENH) ? enhanced_feature_reg : 8'h00;

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      host_data_bus_out <= 8'h00;
      host_data_bus_oe <= 1'b0;
      irq_out <= 1'b0;
      sleep_out <= 1'b0;
    end
    else
    begin
      if (rd_go)
      begin
        host_data_bus_out <= rd_mux;
        host_data_bus_oe <= 1'b1;
      end
      else if (rd_end)
      begin
        host_data_bus_oe <= 1'b0;
      end
      irq_out <= |live;
      sleep_out <= irq_mask_reg[MASK_SLEEP] & ~tx_busy & ~rx_any &
        (tx_count_reg == 8'h00) & (rx_state_reg == RX_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  a_mask_reset: assert property (@(posedge ref_clk) !reset_n |=> irq_mask_reg == 8'h00)
    else $error("mask not cleared by reset");
  a_mask_guard: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_mask && !enhanced_feature_reg[ENH_ENABLE] |=> $stable(irq_mask_reg[7:4]))
    else $error("upper mask bits written without enhanced enable");
  a_start_reject: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rx_state_reg == RX_START && rx_mid && p_rx |=> rx_state_reg == RX_IDLE)
    else $error("false start not discarded");
  a_start_wait: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rx_state_reg == RX_IDLE && rx_fall |=> rx_state_reg == RX_START && rx_cnt_reg == 5'h00)
    else $error("start count not begun on falling edge");
  a_hold_push: assert property (@(posedge ref_clk) disable iff (!reset_n)
    tx_push && !tx_pop && !tx_clr |=> tx_count_reg == $past(tx_count_reg) + 8'h01)
    else $error("holding write did not reach transmit FIFO");
  a_hold_pop: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rx_pop && !rx_push && !rx_clr |=> rx_count_reg == $past(rx_count_reg) - 8'h01)
    else $error("holding read did not remove a byte");
  a_data_ready: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rx_push && !rx_clr |=> line_state_reg[0])
    else $error("data ready not set after receive");
  a_shift_empty: assert property (@(posedge ref_clk) disable iff (!reset_n)
    line_state_reg[6] |-> tx_line)
    else $error("transmitter empty while line not idle");
  a_polled_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
    polled ##1 polled |-> !irq_out)
    else $error("interrupt raised in polled mode");
  a_cts_irq: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cts_rise && irq_mask_reg[7] && !polled ##1 !polled && $stable(irq_mask_reg) |=> irq_out)
    else $error("cts rise gave no interrupt");
  a_drain_irq: assert property (@(posedge ref_clk) disable iff (!reset_n)
    tx_drain && !tx_clr |=> tx_space_pend_reg)
    else $error("drained FIFO left tx space unset");
endmodule

/* File: pkg/uart_pkg.sv */
// Purpose: shared constants, types and helpers for the uart holding and interrupt block
// Assumes: 20 MHz ref_clk, 8 data bits, one stop bit, no parity
// Notes: register offsets are the 3-bit host address values
package uart_pkg;
  localparam int FIFO_DEPTH = 128;
  localparam int PTR_W = 7;
  localparam int PIN_W = 20;
  // strobes and rx preset idle high, modem levels idle low: no false change after reset
  localparam logic [PIN_W-1:0] PIN_RST = 20'hfffe0;
  localparam logic [2:0] OFS_HOLD = 3'h0;
  localparam logic [2:0] OFS_MASK = 3'h1;
  localparam logic [2:0] OFS_SRC_CTRL = 3'h2;
  localparam logic [2:0] OFS_SAMPLE = 3'h3;
  localparam logic [2:0] OFS_LINE = 3'h5;
  localparam logic [2:0] OFS_MODEM = 3'h6;
  localparam logic [2:0] OFS_ENH = 3'h7;
  localparam int MASK_SLEEP = 4;
  localparam int ENH_ENABLE = 4;
  localparam int CTRL_FIFO_EN = 0;
  localparam int CTRL_RX_CLR = 1;
  localparam int CTRL_TX_CLR = 2;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] ENH_RST = 8'h00;
  localparam logic [1:0] TRIG_RST = 2'h0;
  localparam logic [1:0] SAMPLE_RST = 2'h0;
  localparam logic [7:0] XOFF_CHAR = 8'h13;
  localparam logic [7:0] TICK_DIV = 8'h0a;
  localparam logic [5:0] SRC_NONE = 6'h01;
  localparam logic [5:0] SRC_LINE = 6'h06;
  localparam logic [5:0] SRC_RX = 6'h04;
  localparam logic [5:0] SRC_TX = 6'h02;
  localparam logic [5:0] SRC_MODEM = 6'h00;
  localparam logic [5:0] SRC_XOFF = 6'h10;
  localparam logic [5:0] SRC_FLOW = 6'h20;

  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10,
    RX_STOP = 2'b11} rx_state_t;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_LOAD = 2'b01, TX_SEND = 2'b10} tx_state_t;

  // per-bit debounce: a bit moves once stages two and three agree
  function automatic logic [PIN_W-1:0] settle(input logic [PIN_W-1:0] s2,
    input logic [PIN_W-1:0] s3, input logic [PIN_W-1:0] cur);
    settle = (s2 & ~(s2 ^ s3)) | (cur & (s2 ^ s3));
  endfunction

  function automatic logic [4:0] osr_of(input logic [1:0] sel);
    case (sel)
      2'h0: osr_of = 5'h10;
      2'h1: osr_of = 5'h08;
      default: osr_of = 5'h04;
    endcase
  endfunction

  function automatic logic [7:0] rx_trigger(input logic [1:0] sel);
    case (sel)
      2'h0: rx_trigger = 8'h08;
      2'h1: rx_trigger = 8'h10;
      2'h2: rx_trigger = 8'h18;
      default: rx_trigger = 8'h1c;
    endcase
  endfunction

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = p + 7'h01;
  endfunction
endpackage

/* File: verilog/fifo_store.sv */
// Purpose: 128-entry storage for one FIFO, registered read data
// Assumes: pointers handled by the caller
// Notes: read data lags the read address by one clock
`timescale 1ns/1ns
module fifo_store
  import uart_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [PTR_W-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [PTR_W-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [FIFO_DEPTH];

  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

/* File: testbench/host_bus_model.sv */
// Purpose: host processor model on the parallel register bus
// Assumes: strobes held about ten clocks low and ten high
// Notes: released data lines show the inverse of the last byte
`timescale 1ns/1ns
module host_bus_model
(
  input wire logic ref_clk,
  input wire logic [7:0] host_data_bus_out,
  input wire logic host_data_bus_oe,
  output logic [2:0] host_addr,
  output logic [7:0] host_data_bus_in,
  output logic host_cs_n,
  output logic host_rd_n,
  output logic host_wr_n
);
  initial
  begin
    host_addr = 3'h0;
    host_data_bus_in = 8'h00;
    host_cs_n = 1'b1;
    host_rd_n = 1'b1;
    host_wr_n = 1'b1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    host_addr = a;
    host_data_bus_in = d;
    host_cs_n = 1'b0;
    host_wr_n = 1'b0;
    step(10);
    host_wr_n = 1'b1;
    step(10);
    host_cs_n = 1'b1;
    host_data_bus_in = ~d;
    step(10);
  endtask
  // one read takes one byte and frees the strobe afterwards
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    int n;
    n = 0;
    host_addr = a;
    host_cs_n = 1'b0;
    host_rd_n = 1'b0;
    while (host_data_bus_oe !== 1'b1 && n < 30)
    begin
      step(1);
      n++;
    end
    d = host_data_bus_out;
    step(4);
    host_rd_n = 1'b1;
    step(10);
    host_cs_n = 1'b1;
    step(10);
  endtask
endmodule

/* File: testbench/uart_holding_and_irq_mask_tb.sv */
// Purpose: self-checking bench for holding paths and interrupt masks
// Assumes: oversample 4, ten clocks per tick, so forty clocks per bit
// Notes: modem pins driven from the bench, idle low
`timescale 1ns/1ns
module uart_holding_and_irq_mask_tb;
  import uart_pkg::*;
  logic ref_clk, reset_n, rx_line, cts_pin, host_cs_n, host_rd_n, host_wr_n;
  logic host_data_bus_oe, tx_line, irq_out, sleep_out;
  logic rts_pin, dsr_pin, ri_pin, cd_pin;
  logic [2:0] host_addr;
  logic [7:0] host_data_bus_in, host_data_bus_out, b;
  int miscompares, samples_checked;
  ////////////////////////////////////////////////////////////////////////
  uart_holding_irq i_uart_holding_irq (.ref_clk(ref_clk), .reset_n(reset_n),
    .host_addr(host_addr), .host_data_bus_in(host_data_bus_in), .host_cs_n(host_cs_n),
    .host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .rx_line(rx_line), .cts_pin(cts_pin),
    .rts_pin(rts_pin), .dsr_pin(dsr_pin), .ri_pin(ri_pin), .cd_pin(cd_pin),
    .host_data_bus_out(host_data_bus_out), .host_data_bus_oe(host_data_bus_oe),
    .tx_line(tx_line), .irq_out(irq_out), .sleep_out(sleep_out));
  host_bus_model i_host_bus_model (.ref_clk(ref_clk), .host_data_bus_out(host_data_bus_out),
    .host_data_bus_oe(host_data_bus_oe), .host_addr(host_addr),
    .host_data_bus_in(host_data_bus_in), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n),
    .host_wr_n(host_wr_n));
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic finish_test();
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host_bus_model.rd(a, d);
    chk(d, exp);
  endtask
  // serial frame, bit 0 first, forty clocks each
  task automatic send(input logic [9:0] f);
    for (int i = 0; i < 10; i++)
    begin
      rx_line = f[i];
      i_host_bus_model.step(40);
    end
  endtask
  task automatic grab(output logic [7:0] d);
    int n;
    n = 0;
    while (tx_line !== 1'b0 && n < 200)
    begin
      i_host_bus_model.step(1);
      n++;
    end
    i_host_bus_model.step(20);
    for (int i = 0; i < 8; i++)
    begin
      i_host_bus_model.step(40);
      d[i] = tx_line;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_host_bus_model.step(20000);
    miscompares++;
    finish_test();
  end
  initial
  begin
    miscompares = 0;
    samples_checked = 0;
    rx_line = 1'b1;
    cts_pin = 1'b0;
    {rts_pin, dsr_pin, ri_pin, cd_pin} = 4'h0;
    reset_n = 1'b0;
    i_host_bus_model.step(20);
    reset_n = 1'b1;
    i_host_bus_model.step(6);
    chk({6'h00, irq_out, sleep_out}, 8'h00);
    rchk(OFS_MASK, MASK_RST);
    chk({7'h00, host_data_bus_oe}, 8'h00);
    rchk(OFS_LINE, 8'h60);
    i_host_bus_model.wr(OFS_MASK, 8'hf0);
    rchk(OFS_MASK, 8'h00);
    i_host_bus_model.wr(OFS_ENH, 8'h10);
    i_host_bus_model.wr(OFS_MASK, 8'h10);
    rchk(OFS_MASK, 8'h10);
    chk({7'h00, sleep_out}, 8'h01);
    i_host_bus_model.wr(OFS_MASK, 8'h00);
    chk({7'h00, sleep_out}, 8'h00);
    i_host_bus_model.wr(OFS_SAMPLE, 8'h02);
    fork
      i_host_bus_model.wr(OFS_HOLD, 8'ha5);
      grab(b);
    join
    chk(b, 8'ha5);
    i_host_bus_model.step(80);
    rchk(OFS_LINE, 8'h60);
    // glitch shorter than half a bit must not start a character
    rx_line = 1'b0;
    i_host_bus_model.step(8);
    rx_line = 1'b1;
    i_host_bus_model.step(400);
    rchk(OFS_LINE, 8'h60);
    send({1'b1, 8'h3c, 1'b0});
    i_host_bus_model.step(10);
    rchk(OFS_LINE, 8'h61);
    i_host_bus_model.wr(OFS_MASK, 8'h01);
    chk({7'h00, irq_out}, 8'h01);
    rchk(OFS_HOLD, 8'h3c);
    i_host_bus_model.step(2);
    chk({7'h00, irq_out}, 8'h00);
    rchk(OFS_LINE, 8'h60);
    i_host_bus_model.wr(OFS_MASK, 8'h80);
    chk({7'h00, irq_out}, 8'h00);
    cts_pin = 1'b1;
    i_host_bus_model.step(10);
    chk({7'h00, irq_out}, 8'h01);
    i_host_bus_model.rd(OFS_SRC_CTRL, b);
    chk(b, {2'b00, SRC_FLOW});
    chk({7'h00, irq_out}, 8'h00);
    i_host_bus_model.wr(OFS_MASK, 8'h02);
    chk({7'h00, irq_out}, 8'h01);
    i_host_bus_model.wr(OFS_MASK, 8'h40);
    chk({7'h00, irq_out}, 8'h00);
    rts_pin = 1'b1;
    i_host_bus_model.step(10);
    chk({7'h00, irq_out}, 8'h01);
    i_host_bus_model.rd(OFS_SRC_CTRL, b);
    chk(b, {2'b00, SRC_FLOW});
    chk({7'h00, irq_out}, 8'h00);
    rchk(OFS_MODEM, 8'h11);
    i_host_bus_model.wr(OFS_MASK, 8'h08);
    chk({7'h00, irq_out}, 8'h00);
    dsr_pin = 1'b1;
    i_host_bus_model.step(10);
    chk({7'h00, irq_out}, 8'h01);
    rchk(OFS_MODEM, 8'h32);
    chk({7'h00, irq_out}, 8'h00);
    ri_pin = 1'b1;
    i_host_bus_model.step(10);
    chk({7'h00, irq_out}, 8'h00);
    ri_pin = 1'b0;
    cd_pin = 1'b1;
    i_host_bus_model.step(10);
    chk({7'h00, irq_out}, 8'h01);
    rchk(OFS_MODEM, 8'hbc);
    i_host_bus_model.wr(OFS_MASK, 8'h20);
    send({1'b1, XOFF_CHAR, 1'b0});
    i_host_bus_model.step(10);
    chk({7'h00, irq_out}, 8'h01);
    i_host_bus_model.rd(OFS_SRC_CTRL, b);
    chk(b, {2'b00, SRC_XOFF});
    rchk(OFS_HOLD, XOFF_CHAR);
    // second byte lands on a full single-entry holding register
    i_host_bus_model.wr(OFS_MASK, 8'h04);
    send({1'b1, 8'h5a, 1'b0});
    send({1'b1, 8'hc3, 1'b0});
    i_host_bus_model.step(10);
    chk({7'h00, irq_out}, 8'h01);
    rchk(OFS_LINE, 8'h63);
    chk({7'h00, irq_out}, 8'h00);
    rchk(OFS_HOLD, 8'h5a);
    // all-zero frame with low stop bit: break and framing
    send(10'h000);
    rx_line = 1'b1;
    i_host_bus_model.step(10);
    chk({7'h00, irq_out}, 8'h01);
    rchk(OFS_LINE, 8'hf9);
    rchk(OFS_HOLD, 8'h00);
    rchk(OFS_LINE, 8'h60);
    i_host_bus_model.wr(OFS_SRC_CTRL, 8'h01);
    i_host_bus_model.wr(OFS_MASK, 8'h02);
    chk({7'h00, irq_out}, 8'h00);
    fork
      i_host_bus_model.wr(OFS_HOLD, 8'h96);
      grab(b);
    join
    chk(b, 8'h96);
    chk({7'h00, irq_out}, 8'h01);
    i_host_bus_model.rd(OFS_SRC_CTRL, b);
    chk(b, {2'b11, SRC_TX});
    chk({7'h00, irq_out}, 8'h00);
    i_host_bus_model.wr(OFS_MASK, 8'h80);
    cts_pin = 1'b0;
    i_host_bus_model.step(10);
    cts_pin = 1'b1;
    i_host_bus_model.step(10);
    chk({7'h00, irq_out}, 8'h00);
    finish_test();
  end
endmodule
